// ---- src/frf_pkg.sv ----
package frf_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_INT_EXC  = 8'h00;
  localparam logic [7:0] ADDR_MQ_EXT   = 8'h04;
  localparam logic [7:0] ADDR_FP_SC    = 8'h08;
  localparam logic [7:0] ADDR_MACH_ST  = 8'h0C;

  // Integer exception flags, bit n counted from the MSB maps to index 31-n
  localparam int XER_SO     = 31;
  localparam int XER_OV     = 30;
  localparam int XER_CA     = 29;
  localparam int XER_CMP_LO = 8;
  localparam int XER_CMP_HI = 15;
  localparam int XER_CNT_LO = 0;
  localparam int XER_CNT_HI = 6;
  localparam logic [31:0] XER_MASK  = 32'hE000FF7F;
  localparam logic [31:0] XER_RESET = 32'h00000000;
  localparam logic [31:0] MQ_RESET  = 32'h00000000;

  // Float status/control fields (index = 31 - documented bit)
  localparam int FS_FX    = 31;
  localparam int FS_FEX   = 30;
  localparam int FS_VX    = 29;
  localparam int FS_OX    = 28;
  localparam int FS_UX    = 27;
  localparam int FS_ZX    = 26;
  localparam int FS_XX    = 25;
  localparam int FS_VXSN  = 24;
  localparam int FS_VXISI = 23;
  localparam int FS_VXIDI = 22;
  localparam int FS_VXZDZ = 21;
  localparam int FS_VXIMZ = 20;
  localparam int FS_VXVC  = 19;
  localparam int FS_VE    = 7;
  localparam int FS_OE    = 6;
  localparam int FS_UE    = 5;
  localparam int FS_ZE    = 4;
  localparam int FS_XE    = 3;
  localparam logic [31:0] FS_MASK  = 32'hFFFFF3FB;
  localparam logic [31:0] FS_RESET = 32'h00000000;

  // Machine state control bits
  localparam int MS_FP = 0;
  localparam int MS_FE = 1;
  localparam logic [1:0] MS_RESET = 2'h0;

  // Format conversion constants
  localparam logic [10:0] EXP_BIAS_DIFF = 11'h380;
  localparam logic [10:0] EXP_DEN_LOW   = 11'h36A;
  localparam logic [10:0] EXP_DEN_NORM  = 11'h39E;

  typedef enum logic [1:0] {
    INT_ADD   = 2'b00,
    INT_SUB   = 2'b01,
    INT_CMP   = 2'b10,
    INT_WRITE = 2'b11
  } frf_int_op_e;

  typedef enum logic [2:0] {
    FP_ARITH   = 3'b000,
    FP_COMPARE = 3'b001,
    FP_LOAD_S  = 3'b010,
    FP_LOAD_D  = 3'b011,
    FP_STORE_S = 3'b100,
    FP_STORE_D = 3'b101
  } frf_fp_op_e;

  typedef struct packed {
    logic        valid;
    frf_int_op_e op;
    logic [4:0]  dest;
    logic [31:0] a;
    logic [31:0] b;
  } frf_int_req_s;

  typedef struct packed {
    logic snan;
    logic isi;
    logic idi;
    logic zdz;
    logic imz;
    logic vc;
    logic zero_div;
    logic ovf;
    logic unf;
    logic inexact;
  } frf_fp_exc_s;

  typedef struct packed {
    logic        valid;
    frf_fp_op_e  op;
    logic [4:0]  reg_idx;
    logic [63:0] data;
    frf_fp_exc_s exc;
  } frf_fp_req_s;

endpackage

// ---- src/frf_regfile.sv ----
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - Thirty-two 32-bit general registers hold all integer operands.
// - Summary overflow is set with overflow and stays until software clears it.
// - Add/subtract overflow is carry out of MSB differing from carry out of next bit.
// - Add/subtract carry flag is the carry out of the MSB.
// - Compares leave summary overflow, overflow and carry unchanged.
// - Bits 16..23 of the exception flags give the string compare byte.
// - Bits 25..31 of the exception flags give the string byte count.
// - A 32-bit extension register holds product or dividend parts.
// - The extension register also serves long shifts and string store staging.
// - Float available low suppresses float instructions and raises unavailable interrupt.
// - Invalid, zero divide, overflow, underflow and inexact exceptions are detected.
// - Every exception and invalid sub-class has a status bit; each exception an enable.
// - Enabled exception with interrupt enable set gives a precise program interrupt.
// - Thirty-two float registers, selected by a 5-bit specifier.
// - Float registers are 64 bits and hold double-precision values.
// - Float operations read and write float registers and record status.
// - Double loads and stores move 64 bits unchanged.
// - Single loads widen to double; single stores narrow to single by truncation.
// - Enabled exception summary is the OR of status bits masked by enables.
module frf_regfile
  import frf_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Integer execution
  input  wire frf_int_req_s int_req,
  input  wire logic [4:0]   int_rd_idx,
  output logic [31:0]       int_rd_data,
  input  wire logic         mq_we,
  input  wire logic [31:0]  mq_wdata,
  output logic [31:0]       mq_ext,
  output logic [7:0]        str_cmp_byte,
  output logic [6:0]        str_byte_count,
  // Float execution
  input  wire frf_fp_req_s  fp_req,
  input  wire logic [4:0]   fp_rd_idx,
  output logic [63:0]       fp_rd_data,
  output logic [31:0]       fp_store_data_s,
  output logic [63:0]       fp_store_data_d,
  output logic              fp_store_valid,
  output logic              fp_unavail_irq,
  output logic              fp_program_irq
);

  function automatic logic [63:0] single_to_double(input logic [31:0] w);
    logic [52:0] m;
    logic [4:0]  p;
    logic [10:0] e;
    m = 53'h0;
    p = 5'h0;
    e = 11'h0;
    for (int i = 0; i < 23; i++)
    begin
      if (w[i])
        p = 5'(i);
    end
    if (w[30:23] == 8'hFF)
      single_to_double = {w[31], 11'h7FF, w[22:0], 29'h0};
    else if (w[30:23] != 8'h00)
      single_to_double = {w[31], {3'h0, w[30:23]} + EXP_BIAS_DIFF, w[22:0], 29'h0};
    else if (w[22:0] == 23'h0)
      single_to_double = {w[31], 63'h0};
    else
    begin
      // Denormal single becomes a normal double: renormalise the fraction
      m = {30'h0, w[22:0]} << (6'd52 - {1'b0, p});
      e = EXP_DEN_LOW + {6'h0, p};
      single_to_double = {w[31], e, m[51:0]};
    end
  endfunction

  function automatic logic [31:0] double_to_single(input logic [63:0] d);
    logic [52:0] m;
    logic [10:0] sh;
    m = {1'b1, d[51:0]};
    sh = 11'h0;
    if (d[62:52] > EXP_BIAS_DIFF)
      double_to_single = {d[63], d[62], d[58:29]};
    else if (d[62:52] >= EXP_DEN_LOW)
    begin
      // Below single normal range: shift into a single denormal, truncating
      sh = EXP_DEN_NORM - d[62:52];
      m = m >> sh;
      double_to_single = {d[63], 8'h00, m[22:0]};
    end
    else
      double_to_single = {d[63], 31'h0};
  endfunction

  logic [31:0] general_register [32];
  logic [63:0] float_register [32];
  logic [31:0] integer_exception_flags;
  logic [31:0] float_status_control;
  logic [1:0]  msr;
  logic [31:0] next_prdata;
  logic        next_err;
  logic        wr_en;
  logic        fp_go;
  logic [32:0] sum;
  logic [31:0] b_eff;
  logic        carry_in;
  logic        c_into_msb;
  logic        is_addsub;
  logic [31:0] fs_new;
  logic [31:0] fs_stat;
  logic        fex_now;

  // Zero-wait answers would need a combinational pready; one extra cycle keeps it registered
  assign wr_en = psel && penable && pready && pwrite;
  assign fp_go = fp_req.valid && msr[MS_FP];

  always_comb
  begin
    next_err = 1'b0;
    case (paddr)
      ADDR_INT_EXC: next_prdata = integer_exception_flags & XER_MASK;
      ADDR_MQ_EXT:  next_prdata = mq_ext;
      ADDR_FP_SC:   next_prdata = float_status_control;
      ADDR_MACH_ST: next_prdata = {30'h0, msr};
      default:
      begin
        next_prdata = 32'h00000000;
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h00000000;
      pslverr <= psel && penable && !pready && next_err;
    end
  end

  // Integer adder shared by add and subtract
  always_comb
  begin
    is_addsub = int_req.valid && (int_req.op == INT_ADD || int_req.op == INT_SUB);
    b_eff = (int_req.op == INT_SUB) ? ~int_req.b : int_req.b;
    carry_in = (int_req.op == INT_SUB);
    sum = {1'b0, int_req.a} + {1'b0, b_eff} + {32'h0, carry_in};
    c_into_msb = int_req.a[31] ^ b_eff[31] ^ sum[31];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
        general_register[i] <= 32'h00000000;
    end
    else if (int_req.valid && int_req.op != INT_CMP)
      general_register[int_req.dest] <= (int_req.op == INT_WRITE) ? int_req.b : sum[31:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_rd_data <= 32'h00000000;
    else
      int_rd_data <= general_register[int_rd_idx];
  end

  // Hardware flag updates follow the software write so a set is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      integer_exception_flags <= XER_RESET;
    else
    begin
      if (wr_en && paddr == ADDR_INT_EXC)
        integer_exception_flags <= pwdata & XER_MASK;
      if (is_addsub)
      begin
        integer_exception_flags[XER_OV] <= sum[32] ^ c_into_msb;
        integer_exception_flags[XER_CA] <= sum[32];
        if (sum[32] ^ c_into_msb)
          integer_exception_flags[XER_SO] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      str_cmp_byte <= 8'h00;
      str_byte_count <= 7'h00;
    end
    else
    begin
      str_cmp_byte <= integer_exception_flags[XER_CMP_HI:XER_CMP_LO];
      str_byte_count <= integer_exception_flags[XER_CNT_HI:XER_CNT_LO];
    end
  end

  // Pipeline write wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mq_ext <= MQ_RESET;
    else if (mq_we)
      mq_ext <= mq_wdata;
    else if (wr_en && paddr == ADDR_MQ_EXT)
      mq_ext <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      msr <= MS_RESET;
    else if (wr_en && paddr == ADDR_MACH_ST)
      msr <= pwdata[1:0];
  end

  // New exception status from the current float operation
  always_comb
  begin
    fs_new = 32'h00000000;
    if (fp_go && (fp_req.op == FP_ARITH || fp_req.op == FP_COMPARE))
    begin
      fs_new[FS_VXSN] = fp_req.exc.snan;
      fs_new[FS_VXISI] = fp_req.exc.isi;
      fs_new[FS_VXIDI] = fp_req.exc.idi;
      fs_new[FS_VXZDZ] = fp_req.exc.zdz;
      fs_new[FS_VXIMZ] = fp_req.exc.imz;
      fs_new[FS_VXVC] = fp_req.exc.vc;
      fs_new[FS_ZX] = fp_req.exc.zero_div;
      fs_new[FS_OX] = fp_req.exc.ovf;
      fs_new[FS_UX] = fp_req.exc.unf;
      fs_new[FS_XX] = fp_req.exc.inexact;
    end
    fs_stat = ((wr_en && paddr == ADDR_FP_SC) ? (pwdata & FS_MASK) : float_status_control) | fs_new;
    fs_stat[FS_VX] = |fs_stat[FS_VXSN:FS_VXVC];
    if (|(fs_new & ~float_status_control))
      fs_stat[FS_FX] = 1'b1;
    fex_now = (fs_stat[FS_VX] & fs_stat[FS_VE]) | (fs_stat[FS_OX] & fs_stat[FS_OE])
            | (fs_stat[FS_UX] & fs_stat[FS_UE]) | (fs_stat[FS_ZX] & fs_stat[FS_ZE])
            | (fs_stat[FS_XX] & fs_stat[FS_XE]);
    fs_stat[FS_FEX] = fex_now;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      float_status_control <= FS_RESET;
    else
      float_status_control <= fs_stat;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
        float_register[i] <= 64'h0;
    end
    else if (fp_go)
    begin
      case (fp_req.op)
        FP_ARITH:  float_register[fp_req.reg_idx] <= fp_req.data;
        FP_LOAD_D: float_register[fp_req.reg_idx] <= fp_req.data;
        FP_LOAD_S: float_register[fp_req.reg_idx] <= single_to_double(fp_req.data[31:0]);
        default:   float_register[fp_req.reg_idx] <= float_register[fp_req.reg_idx];
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp_rd_data <= 64'h0;
      fp_store_data_s <= 32'h00000000;
      fp_store_data_d <= 64'h0;
      fp_store_valid <= 1'b0;
    end
    else
    begin
      fp_rd_data <= float_register[fp_rd_idx];
      fp_store_valid <= fp_go && (fp_req.op == FP_STORE_S || fp_req.op == FP_STORE_D);
      if (fp_go && fp_req.op == FP_STORE_D)
        fp_store_data_d <= float_register[fp_req.reg_idx];
      if (fp_go && fp_req.op == FP_STORE_S)
        fp_store_data_s <= double_to_single(float_register[fp_req.reg_idx]);
    end
  end

  // Interrupt is precise: raised in the cycle after the offending instruction only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp_unavail_irq <= 1'b0;
      fp_program_irq <= 1'b0;
    end
    else
    begin
      fp_unavail_irq <= fp_req.valid && !msr[MS_FP];
      fp_program_irq <= msr[MS_FE] && (|fs_new) && fex_now;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_so_sticky: assert property (integer_exception_flags[XER_SO] && !(wr_en && paddr == ADDR_INT_EXC) |=> integer_exception_flags[XER_SO])
    else $error("summary overflow dropped without software clear");
  chk_ov_addsub: assert property (is_addsub |=> integer_exception_flags[XER_OV] == $past(sum[32] ^ c_into_msb))
    else $error("overflow flag wrong after add/sub");
  chk_ca_addsub: assert property (is_addsub |=> integer_exception_flags[XER_CA] == $past(sum[32]))
    else $error("carry flag wrong after add/sub");
  chk_cmp_flags: assert property (int_req.valid && int_req.op == INT_CMP && !wr_en
    |=> $stable(integer_exception_flags[XER_SO:XER_CA]))
    else $error("compare changed integer flags");
  chk_cnt_follow: assert property ($changed(integer_exception_flags[XER_CNT_HI:XER_CNT_LO])
    |=> str_byte_count == $past(integer_exception_flags[XER_CNT_HI:XER_CNT_LO]))
    else $error("byte count output lags");
  chk_unavail_irq: assert property (fp_req.valid && !msr[MS_FP] |=> fp_unavail_irq && !fp_store_valid)
    else $error("unavailable float op not suppressed");
  chk_fex_or: assert property (float_status_control[FS_FEX] == ((float_status_control[FS_VX] & float_status_control[FS_VE]) | (float_status_control[FS_OX] & float_status_control[FS_OE])
    | (float_status_control[FS_UX] & float_status_control[FS_UE]) | (float_status_control[FS_ZX] & float_status_control[FS_ZE]) | (float_status_control[FS_XX] & float_status_control[FS_XE])))
    else $error("enabled summary mismatch");
  chk_vx_or: assert property (float_status_control[FS_VX] == |float_status_control[FS_VXSN:FS_VXVC])
    else $error("invalid summary mismatch");
  chk_exc_sticky: assert property (fp_go && fp_req.op == FP_ARITH && fp_req.exc.zero_div |=> float_status_control[FS_ZX])
    else $error("zero divide status not recorded");
  chk_prog_irq: assert property (fp_program_irq |-> $past(msr[MS_FE]) && float_status_control[FS_FEX])
    else $error("program interrupt without enable");
  chk_load_d: assert property (fp_go && fp_req.op == FP_LOAD_D ##1 fp_rd_idx == $past(fp_req.reg_idx)
    |=> fp_rd_data == $past(fp_req.data, 2))
    else $error("double load altered data");
  chk_xer_rsv: assert property (pready && !pwrite && paddr == ADDR_INT_EXC |-> (prdata & ~XER_MASK) == 32'h0)
    else $error("reserved flag bits read nonzero");
  chk_gpr_write: assert property (int_req.valid && int_req.op == INT_WRITE |=> general_register[$past(int_req.dest)] == $past(int_req.b))
    else $error("general register write lost");
  chk_mq_write: assert property (mq_we |=> mq_ext == $past(mq_wdata))
    else $error("extension register missed pipeline write");
  chk_fp_block: assert property (fp_req.valid && !msr[MS_FP] && !wr_en |=> $stable(float_status_control))
    else $error("unavailable float op changed status");
  chk_store_d: assert property (fp_go && fp_req.op == FP_STORE_D |=> fp_store_valid)
    else $error("double store not signalled");

  cov_overflow: cover property (is_addsub ##1 integer_exception_flags[XER_OV]);
  cov_unavail: cover property (fp_unavail_irq);
  cov_prog_irq: cover property (fp_program_irq);
  cov_store_s: cover property (fp_go && fp_req.op == FP_STORE_S ##1 fp_store_valid);
  cov_fs_write: cover property (wr_en && paddr == ADDR_FP_SC);

endmodule

// ---- test/frf_pipe_model.sv ----
`timescale 1ns/1ps
module frf_pipe_model
  import frf_pkg::*;
(
  // Clock
  input  wire logic    pclk,
  // Integer issue
  output frf_int_req_s int_req,
  output logic [4:0]   int_rd_idx,
  output logic         mq_we,
  output logic [31:0]  mq_wdata,
  // Float issue
  output frf_fp_req_s  fp_req,
  output logic [4:0]   fp_rd_idx
);
  initial
  begin
    int_req = '0;
    int_rd_idx = 5'h00;
    mq_we = 1'b0;
    mq_wdata = 32'h0;
    fp_req = '0;
    fp_rd_idx = 5'h00;
  end

  // Operands are inverted after issue so a stale request never looks like a fresh one
  task automatic int_op(input frf_int_op_e op, input logic [4:0] d, input logic [31:0] a, input logic [31:0] b);
    @(posedge pclk);
    int_req <= '{1'b1, op, d, a, b};
    int_rd_idx <= d;
    @(posedge pclk);
    int_req <= '{1'b0, op, d, ~a, ~b};
    #1;
  endtask

  task automatic mq_op(input logic [31:0] d);
    @(posedge pclk);
    mq_we <= 1'b1;
    mq_wdata <= d;
    @(posedge pclk);
    mq_we <= 1'b0;
    mq_wdata <= ~d;
    #1;
  endtask

  task automatic fp_op(input frf_fp_op_e op, input logic [4:0] i, input logic [63:0] d, input frf_fp_exc_s e);
    @(posedge pclk);
    fp_req <= '{1'b1, op, i, d, e};
    fp_rd_idx <= i;
    @(posedge pclk);
    fp_req <= '{1'b0, op, i, ~d, ~e};
    #1;
  endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import frf_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  frf_int_req_s int_req;
  logic [4:0]   int_rd_idx;
  logic [31:0]  int_rd_data;
  logic         mq_we;
  logic [31:0]  mq_wdata;
  logic [31:0]  mq_ext;
  logic [7:0]   str_cmp_byte;
  logic [6:0]   str_byte_count;
  frf_fp_req_s  fp_req;
  logic [4:0]   fp_rd_idx;
  logic [63:0]  fp_rd_data;
  logic [31:0]  fp_store_data_s;
  logic [63:0]  fp_store_data_d;
  logic         fp_store_valid;
  logic         fp_unavail_irq;
  logic         fp_program_irq;
  int           mismatches;
  int           checks;
  int           pos[10] = '{FS_VXSN, FS_VXISI, FS_VXIDI, FS_VXZDZ, FS_VXIMZ, FS_VXVC, FS_ZX, FS_OX, FS_UX, FS_XX};

  frf_regfile u_frf_regfile (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_req(int_req),
    .int_rd_idx(int_rd_idx), .int_rd_data(int_rd_data), .mq_we(mq_we), .mq_wdata(mq_wdata), .mq_ext(mq_ext),
    .str_cmp_byte(str_cmp_byte), .str_byte_count(str_byte_count), .fp_req(fp_req), .fp_rd_idx(fp_rd_idx),
    .fp_rd_data(fp_rd_data), .fp_store_data_s(fp_store_data_s), .fp_store_data_d(fp_store_data_d),
    .fp_store_valid(fp_store_valid), .fp_unavail_irq(fp_unavail_irq), .fp_program_irq(fp_program_irq));
  frf_pipe_model u_frf_pipe_model (.pclk(pclk), .int_req(int_req), .int_rd_idx(int_rd_idx), .mq_we(mq_we),
    .mq_wdata(mq_wdata), .fp_req(fp_req), .fp_rd_idx(fp_rd_idx));

  always #12.5 pclk = ~pclk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      summarize();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check("prdata", rd, exp);
    check("pslverr", err, err_exp);
  endtask

  task automatic settle;
    @(posedge pclk);
    #1;
  endtask

  initial
  begin
    #2ms;
    mismatches++;
    summarize();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(ADDR_INT_EXC, XER_RESET, 1'b0);
    rchk(ADDR_MQ_EXT, MQ_RESET, 1'b0);
    rchk(ADDR_FP_SC, FS_RESET, 1'b0);
    rchk(ADDR_MACH_ST, 32'h0, 1'b0);
    rchk(8'h10, 32'h0, 1'b1);
    // Signed overflow without carry, then carry without overflow
    u_frf_pipe_model.int_op(INT_ADD, 5'h1F, 32'h7FFFFFFF, 32'h00000001);
    settle();
    check("gpr", int_rd_data, 32'h80000000);
    rchk(ADDR_INT_EXC, 32'hC0000000, 1'b0);
    u_frf_pipe_model.int_op(INT_ADD, 5'h00, 32'hFFFFFFFF, 32'h00000001);
    rchk(ADDR_INT_EXC, 32'hA0000000, 1'b0);
    u_frf_pipe_model.int_op(INT_CMP, 5'h03, 32'h7FFFFFFF, 32'h00000001);
    rchk(ADDR_INT_EXC, 32'hA0000000, 1'b0);
    u_frf_pipe_model.int_op(INT_SUB, 5'h01, 32'h80000000, 32'h00000001);
    settle();
    check("gpr", int_rd_data, 32'h7FFFFFFF);
    rchk(ADDR_INT_EXC, 32'hE0000000, 1'b0);
    wr(ADDR_INT_EXC, 32'h0);
    u_frf_pipe_model.int_op(INT_ADD, 5'h02, 32'h00000001, 32'h00000001);
    rchk(ADDR_INT_EXC, 32'h0, 1'b0);
    wr(ADDR_INT_EXC, 32'hFFFFFFFF);
    settle();
    check("cmp_byte", str_cmp_byte, 8'hFF);
    check("byte_count", str_byte_count, 7'h7F);
    rchk(ADDR_INT_EXC, XER_MASK, 1'b0);
    wr(ADDR_INT_EXC, 32'h00003A05);
    settle();
    check("cmp_byte", str_cmp_byte, 8'h3A);
    check("byte_count", str_byte_count, 7'h05);
    // Every general register keeps its own value
    for (int i = 0; i < 32; i++)
      u_frf_pipe_model.int_op(INT_WRITE, 5'(i), 32'h0, 32'hA5000000 | 32'(i));
    for (int i = 0; i < 32; i++)
    begin
      u_frf_pipe_model.int_op(INT_CMP, 5'(i), 32'h0, 32'h0);
      settle();
      check("gpr", int_rd_data, 32'hA5000000 | 32'(i));
    end
    wr(ADDR_MQ_EXT, 32'hA5A5C3C3);
    rchk(ADDR_MQ_EXT, 32'hA5A5C3C3, 1'b0);
    u_frf_pipe_model.mq_op(32'h5A5A1234);
    check("mq_ext", mq_ext, 32'h5A5A1234);
    rchk(ADDR_MQ_EXT, 32'h5A5A1234, 1'b0);
    // Float unit unavailable: load suppressed
    u_frf_pipe_model.fp_op(FP_LOAD_D, 5'h05, 64'h1122334455667788, '0);
    check("unavail_irq", fp_unavail_irq, 1'b1);
    settle();
    check("unavail_irq", fp_unavail_irq, 1'b0);
    check("fpr", fp_rd_data, 64'h0);
    wr(ADDR_MACH_ST, 32'h00000003);
    u_frf_pipe_model.fp_op(FP_LOAD_D, 5'h05, 64'h400921FB54442D18, '0);
    check("unavail_irq", fp_unavail_irq, 1'b0);
    settle();
    check("fpr", fp_rd_data, 64'h400921FB54442D18);
    u_frf_pipe_model.fp_op(FP_LOAD_S, 5'h1F, 64'hFFFFFFFFC0200000, '0);
    settle();
    check("fpr", fp_rd_data, 64'hC004000000000000);
    u_frf_pipe_model.fp_op(FP_STORE_S, 5'h1F, 64'h0, '0);
    check("store_valid", fp_store_valid, 1'b1);
    check("store_s", fp_store_data_s, 32'hC0200000);
    u_frf_pipe_model.fp_op(FP_STORE_D, 5'h05, 64'h0, '0);
    check("store_d", fp_store_data_d, 64'h400921FB54442D18);
    // Smallest single denormal survives the round trip
    u_frf_pipe_model.fp_op(FP_LOAD_S, 5'h1E, 64'h0000000000000001, '0);
    settle();
    check("fpr", fp_rd_data, 64'h36A0000000000000);
    u_frf_pipe_model.fp_op(FP_STORE_S, 5'h1E, 64'h0, '0);
    check("store_s", fp_store_data_s, 32'h00000001);
    // Each exception kind with all enables off
    for (int i = 0; i < 10; i++)
    begin
      wr(ADDR_FP_SC, 32'h0);
      u_frf_pipe_model.fp_op(FP_ARITH, 5'h09, 64'h3FF0000000000000 + 64'(i), frf_fp_exc_s'(10'h200 >> i));
      check("program_irq", fp_program_irq, 1'b0);
      rchk(ADDR_FP_SC, (32'h1 << FS_FX) | (32'h1 << pos[i]) | (32'(i < 6) << FS_VX), 1'b0);
    end
    check("fpr", fp_rd_data, 64'h3FF0000000000009);
    // Masked exception, then an enabled one
    wr(ADDR_FP_SC, 32'h1 << FS_ZE);
    u_frf_pipe_model.fp_op(FP_ARITH, 5'h0A, 64'h0, 10'h004);
    check("program_irq", fp_program_irq, 1'b0);
    rchk(ADDR_FP_SC, 32'h90000010, 1'b0);
    u_frf_pipe_model.fp_op(FP_COMPARE, 5'h0A, 64'h0, 10'h008);
    check("program_irq", fp_program_irq, 1'b1);
    rchk(ADDR_FP_SC, 32'hD4000010, 1'b0);
    wr(ADDR_MACH_ST, 32'h00000001);
    wr(ADDR_FP_SC, 32'h1 << FS_ZE);
    u_frf_pipe_model.fp_op(FP_ARITH, 5'h0A, 64'h0, 10'h008);
    check("program_irq", fp_program_irq, 1'b0);
    rchk(ADDR_FP_SC, 32'hC4000010, 1'b0);
    wr(ADDR_FP_SC, 32'h1 << FS_XE);
    rchk(ADDR_FP_SC, 32'h00000008, 1'b0);
    wr(ADDR_FP_SC, 32'hFFFFFFFF);
    rchk(ADDR_FP_SC, 32'hFFFFF3FB, 1'b0);
    summarize();
  end
endmodule
